// file: pgdec_top.sv
`timescale 1ns/1ns
`include "pgdec_defines.svh"

// Notes on behaviour
// - Readable, writable page register at offset E0h.
// - Page bits feed the address decode array.
// - Page bits also feed general logic array.
// - Page register loads and drives data lines 0-7.
// - Fast mode off: idle arrays enter standby.
// - Five block bits mask host control signals.
// - Arrays share one 73-signal input bus.
// - Wide address mode uses address bits 19-4.
// - Eight primary selects, three terms each.
// - Four secondary selects, three terms each.
// - One SRAM select from two terms.
// - Config, test-port and two peripheral selects.
// - Three dedicated external chip selects.
// - 24 input cells, 16 output cells, 137 terms.
// - Host loads output cells and reads all cells directly.
// - Secondary sector wins over overlapping primary.
// - SRAM enabled only while its select is high.
module pgdec_top (
  // Clock and reset
  input  wire logic                   clk_sys_i,
  input  wire logic                   sys_rst_i,
  // Host bus pins
  input  wire logic [19:0]            host_addr_i,
  input  wire logic [7:0]             host_data_i,
  output logic      [7:0]             host_data_o,
  output logic                        host_data_oe_o,
  input  wire logic                   host_wr_i,
  input  wire logic                   host_rd_i,
  input  wire logic                   host_psen_i,
  input  wire logic                   host_ale_i,
  input  wire logic                   host_aux_i,
  // Other pins
  input  wire logic                   power_down_input_i,
  input  wire logic [7:0]             port_a_i,
  input  wire logic [7:0]             port_b_i,
  input  wire logic [7:0]             port_c_i,
  input  wire logic [2:0]             port_d_i,
  input  wire logic                   sec_ready_i,
  // Configuration levels
  input  wire logic                   addr_wide_i,
  input  wire logic [7:0]             power_mode_reg0_i,
  input  wire logic [4:0]             power_mode_reg2_i,
  input  wire pgdec_pkg::pgdec_tcfg_t term_care_i,
  input  wire pgdec_pkg::pgdec_tcfg_t term_value_i,
  // Selects
  output logic      [7:0]             primary_sector_selects_o,
  output logic      [3:0]             secondary_sector_selects_o,
  output logic                        sram_select_o,
  output logic                        sram_enable_o,
  output logic                        config_register_space_o,
  output logic                        test_port_select_o,
  output logic      [1:0]             periph_selects_o,
  output logic      [2:0]             external_chip_selects_o,
  // State
  output logic      [15:0]            output_cells_o,
  output logic      [7:0]             page_bits_o,
  output logic                        arrays_standby_o
);

  localparam int SYNC_W = 62;
  localparam logic [3:0] IDLE_CYC = 4'(`PGDEC_IDLE_CYC);

  // ******************************************************************
  // Input synchroniser
  // ******************************************************************
  logic [SYNC_W-1:0] sync1_reg, sync1_next, sync2_reg, sync2_next;

  always_comb begin
    sync1_next = {host_addr_i, host_data_i, host_aux_i, host_ale_i, host_psen_i,
                  host_rd_i, host_wr_i, power_down_input_i, port_a_i, port_b_i,
                  port_c_i, port_d_i, sec_ready_i};
    sync2_next = sync1_reg;
  end

  always_ff @(posedge clk_sys_i) begin
    sync1_reg <= sync1_next;
    sync2_reg <= sync2_next;
  end

  logic [19:0] a_s;
  logic [7:0]  d_s, pa_s, pb_s, pc_s;
  logic [4:0]  ctl_s;
  logic [2:0]  pd_s;
  logic        pdn_s, rdy_s;
  assign {a_s, d_s, ctl_s, pdn_s, pa_s, pb_s, pc_s, pd_s, rdy_s} = sync2_reg;

  // ******************************************************************
  // Shared array bus and product terms
  // ******************************************************************
  logic [7:0]  page_reg, page_next;
  logic [15:0] oc_reg, oc_next;
  logic [23:0] ic_reg, ic_next;
  logic [4:0]  ctl_eff;
  logic [15:0] arr_addr;
  pgdec_pkg::pgdec_bus_t   bus;
  pgdec_pkg::pgdec_terms_t term;

  assign ctl_eff  = ctl_s & ~power_mode_reg2_i;
  assign arr_addr = addr_wide_i ? a_s[19:4] : a_s[15:0];
  // Input cells hold port A, B and C levels, so those bus lanes come from them.
  assign bus = {rdy_s, oc_reg[15:8], oc_reg[7:0], page_reg, pd_s,
                ic_reg[23:16], ic_reg[15:8], ic_reg[7:0], pdn_s, sys_rst_i,
                ctl_eff[2:0], arr_addr};

  pgdec_pterm pgdec_pterm_inst (
    .bus_i   (bus),
    .care_i  (term_care_i),
    .value_i (term_value_i),
    .term_o  (term)
  );

  // ******************************************************************
  // Host access to the configuration space
  // ******************************************************************
  logic       wr_prev_reg, wr_prev_next;
  logic       oe_reg, oe_next;
  logic [7:0] dout_reg, dout_next;
  logic       cfg_hit, wr_pulse, rd_hit;
  logic [7:0] ofs;

  assign cfg_hit  = term[`PGDEC_T_CFG];
  assign ofs      = a_s[7:0];
  assign wr_pulse = ctl_s[0] & ~wr_prev_reg & cfg_hit;
  assign rd_hit   = ctl_s[1] & cfg_hit &
                    (ofs == `PGDEC_PAGE_OFS || ofs == `PGDEC_OC_AB_OFS ||
                     ofs == `PGDEC_OC_BC_OFS || ofs == `PGDEC_IC_A_OFS ||
                     ofs == `PGDEC_IC_B_OFS || ofs == `PGDEC_IC_C_OFS);

  always_comb begin
    wr_prev_next = ctl_s[0];
    oe_next      = rd_hit;
    unique case (ofs)
      `PGDEC_PAGE_OFS:  dout_next = page_reg;
      `PGDEC_OC_AB_OFS: dout_next = oc_reg[7:0];
      `PGDEC_OC_BC_OFS: dout_next = oc_reg[15:8];
      `PGDEC_IC_A_OFS:  dout_next = ic_reg[7:0];
      `PGDEC_IC_B_OFS:  dout_next = ic_reg[15:8];
      `PGDEC_IC_C_OFS:  dout_next = ic_reg[23:16];
      default:          dout_next = 8'h00;
    endcase
    if (!rd_hit) begin
      dout_next = 8'h00;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      wr_prev_reg <= 1'b0;
      oe_reg      <= 1'b0;
      dout_reg    <= 8'h00;
    end else begin
      wr_prev_reg <= wr_prev_next;
      oe_reg      <= oe_next;
      dout_reg    <= dout_next;
    end
  end

  assign host_data_o    = dout_reg;
  assign host_data_oe_o = oe_reg;

  // ******************************************************************
  // Page register and macrocells
  // ******************************************************************
  always_comb begin
    page_next = page_reg;
    if (wr_pulse && ofs == `PGDEC_PAGE_OFS) begin
      page_next = d_s;
    end
    // Output cells follow their terms; a host load overrides internal logic.
    oc_next = term[`PGDEC_T_GLA+3 +: 16];
    if (wr_pulse && ofs == `PGDEC_OC_AB_OFS) begin
      oc_next[7:0] = d_s;
    end
    if (wr_pulse && ofs == `PGDEC_OC_BC_OFS) begin
      oc_next[15:8] = d_s;
    end
    ic_next = {pc_s, pb_s, pa_s};
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      page_reg <= `PGDEC_PAGE_RST;
      oc_reg   <= 16'h0000;
      ic_reg   <= 24'h00_0000;
    end else begin
      page_reg <= page_next;
      oc_reg   <= oc_next;
      ic_reg   <= ic_next;
    end
  end

  assign page_bits_o    = page_reg;
  assign output_cells_o = oc_reg;

  // ******************************************************************
  // Standby when fast mode is off
  // ******************************************************************
  pgdec_pkg::pgdec_bus_t bus_prev_reg, bus_prev_next;
  logic [1:0]            aux_prev_reg, aux_prev_next;
  pgdec_pkg::pgdec_pwr_e pwr_reg, pwr_next;
  logic [3:0]            idle_reg, idle_next;
  logic                  changed;

  assign changed = (bus != bus_prev_reg) || (ctl_eff[4:3] != aux_prev_reg);

  always_comb begin
    bus_prev_next = bus;
    aux_prev_next = ctl_eff[4:3];
    pwr_next      = pwr_reg;
    idle_next     = idle_reg;
    if (power_mode_reg0_i[`PGDEC_FAST_BIT] || changed) begin
      pwr_next  = pgdec_pkg::PGDEC_ACTIVE;
      idle_next = 4'h0;
    end else begin
      unique case (pwr_reg)
        pgdec_pkg::PGDEC_ACTIVE: begin
          pwr_next  = pgdec_pkg::PGDEC_SETTLE;
          idle_next = 4'h1;
        end
        pgdec_pkg::PGDEC_SETTLE: begin
          idle_next = idle_reg + 4'h1;
          if (idle_next >= IDLE_CYC) begin
            pwr_next = pgdec_pkg::PGDEC_STANDBY;
          end
        end
        pgdec_pkg::PGDEC_STANDBY: begin
          idle_next = idle_reg;
        end
        default: begin
          pwr_next  = pgdec_pkg::PGDEC_ACTIVE;
          idle_next = 4'h0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      bus_prev_reg <= '0;
      aux_prev_reg <= 2'b00;
      pwr_reg      <= pgdec_pkg::PGDEC_ACTIVE;
      idle_reg     <= 4'h0;
    end else begin
      bus_prev_reg <= bus_prev_next;
      aux_prev_reg <= aux_prev_next;
      pwr_reg      <= pwr_next;
      idle_reg     <= idle_next;
    end
  end

  assign arrays_standby_o = (pwr_reg == pgdec_pkg::PGDEC_STANDBY);

  // ******************************************************************
  // Select outputs
  // ******************************************************************
  // In standby the select registers hold; waking costs one clock, which is
  // the price paid for the lower power with fast mode off.
  logic [7:0] pri_reg, pri_next;
  logic [3:0] sec_reg, sec_next;
  logic [1:0] peri_reg, peri_next;
  logic [2:0] ecs_reg, ecs_next;
  logic       sram_reg, sram_next, cfg_reg, cfg_next, test_reg, test_next;
  logic       hi_prio;

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pri_next[i] = |term[`PGDEC_T_PRI+3*i +: 3];
    end
    for (int i = 0; i < 4; i++) begin
      sec_next[i] = |term[`PGDEC_T_SEC+3*i +: 3];
    end
    sram_next = |term[`PGDEC_T_SRAM +: 2];
    cfg_next  = term[`PGDEC_T_CFG];
    test_next = term[`PGDEC_T_TEST];
    peri_next = term[`PGDEC_T_PERI +: 2];
    ecs_next  = term[`PGDEC_T_GLA +: 3];
    // Taken from the raw terms here, so the priority does not loop through itself.
    hi_prio   = sram_next | cfg_next | (|peri_next);
    if (hi_prio) begin
      sec_next = 4'h0;
    end
    if (hi_prio || (|sec_next)) begin
      pri_next = 8'h00;
    end
    if (pwr_reg == pgdec_pkg::PGDEC_STANDBY) begin
      {pri_next, sec_next, sram_next, cfg_next, test_next, peri_next, ecs_next} =
        {pri_reg, sec_reg, sram_reg, cfg_reg, test_reg, peri_reg, ecs_reg};
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      {pri_reg, sec_reg, sram_reg, cfg_reg, test_reg, peri_reg, ecs_reg} <= '0;
    end else begin
      {pri_reg, sec_reg, sram_reg, cfg_reg, test_reg, peri_reg, ecs_reg} <=
        {pri_next, sec_next, sram_next, cfg_next, test_next, peri_next, ecs_next};
    end
  end

  assign primary_sector_selects_o   = pri_reg;
  assign secondary_sector_selects_o = sec_reg;
  assign sram_select_o              = sram_reg;
  assign sram_enable_o              = sram_reg;
  assign config_register_space_o    = cfg_reg;
  assign test_port_select_o         = test_reg;
  assign periph_selects_o           = peri_reg;
  assign external_chip_selects_o    = ecs_reg;

  // ******************************************************************
  // Checks
  // ******************************************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);

  property p_page_write;
    wr_pulse && ofs == `PGDEC_PAGE_OFS |=> page_bits_o == $past(d_s);
  endproperty
  a_page_write: assert property (p_page_write) else $error("page write lost");

  property p_page_hold;
    !(wr_pulse && ofs == `PGDEC_PAGE_OFS) |=> $stable(page_bits_o);
  endproperty
  a_page_hold: assert property (p_page_hold) else $error("page changed");

  property p_page_rst;
    $fell(sys_rst_i) |-> page_bits_o == 8'h00;
  endproperty
  a_page_rst: assert property (p_page_rst) else $error("page not cleared");

  property p_page_read;
    rd_hit && ofs == `PGDEC_PAGE_OFS |=> host_data_oe_o && host_data_o == $past(page_reg);
  endproperty
  a_page_read: assert property (p_page_read) else $error("page read wrong");

  property p_sec_prio;
    |secondary_sector_selects_o |-> primary_sector_selects_o == 8'h00;
  endproperty
  a_sec_prio: assert property (p_sec_prio) else $error("primary overlaps");

  property p_sram_en;
    sram_enable_o == sram_select_o;
  endproperty
  a_sram_en: assert property (p_sram_en) else $error("sram enable wrong");

  property p_standby;
    !power_mode_reg0_i[`PGDEC_FAST_BIT] && !changed ##1
      (!power_mode_reg0_i[`PGDEC_FAST_BIT] && !changed) [*7] |=> arrays_standby_o;
  endproperty
  a_standby: assert property (p_standby) else $error("no standby");

  property p_wake;
    changed || power_mode_reg0_i[`PGDEC_FAST_BIT] |=> !arrays_standby_o;
  endproperty
  a_wake: assert property (p_wake) else $error("standby while busy");

  property p_block;
    power_mode_reg2_i[1] |-> bus[`PGDEC_B_CTL+1] == 1'b0;
  endproperty
  a_block: assert property (p_block) else $error("control not blocked");

  property p_wide;
    addr_wide_i |-> bus[`PGDEC_B_ADDR +: 16] == a_s[19:4];
  endproperty
  a_wide: assert property (p_wide) else $error("wide address wrong");

  property p_oc_load;
    wr_pulse && ofs == `PGDEC_OC_AB_OFS |=> output_cells_o[7:0] == $past(d_s);
  endproperty
  a_oc_load: assert property (p_oc_load) else $error("cell load lost");

endmodule

// file: pgdec_defines.svh
`ifndef PGDEC_DEFINES_SVH
`define PGDEC_DEFINES_SVH

// ********************************************************************
// Register offsets inside the configuration register space
// ********************************************************************
`define PGDEC_PAGE_OFS    8'he0
`define PGDEC_OC_AB_OFS   8'h20
`define PGDEC_OC_BC_OFS   8'h21
`define PGDEC_IC_A_OFS    8'h0a
`define PGDEC_IC_B_OFS    8'h0b
`define PGDEC_IC_C_OFS    8'h18
`define PGDEC_PAGE_RST    8'h00

// ********************************************************************
// Power mode fields
// ********************************************************************
`define PGDEC_FAST_BIT    3
`define PGDEC_NBLOCK      5

// ********************************************************************
// Timing
// ********************************************************************
`define PGDEC_IDLE_NS     70
`define PGDEC_CLK_NS      10
`define PGDEC_IDLE_CYC    ((`PGDEC_IDLE_NS + `PGDEC_CLK_NS - 1) / `PGDEC_CLK_NS)

// ********************************************************************
// Shared array input bus layout
// ********************************************************************
`define PGDEC_BUS_W       73
`define PGDEC_B_ADDR      0
`define PGDEC_B_CTL       16
`define PGDEC_B_RST       19
`define PGDEC_B_PDN       20
`define PGDEC_B_PA        21
`define PGDEC_B_PB        29
`define PGDEC_B_PC        37
`define PGDEC_B_PD        45
`define PGDEC_B_PAGE      48
`define PGDEC_B_FBAB      56
`define PGDEC_B_FBBC      64
`define PGDEC_B_RDY       72

// ********************************************************************
// Product term layout
// ********************************************************************
`define PGDEC_NTERMS      179
`define PGDEC_T_PRI       0
`define PGDEC_T_SEC       24
`define PGDEC_T_SRAM      36
`define PGDEC_T_CFG       38
`define PGDEC_T_TEST      39
`define PGDEC_T_PERI      40
`define PGDEC_T_GLA       42
`define PGDEC_GLA_TERMS   137

`endif

// file: pgdec_pkg.sv
`include "pgdec_defines.svh"

package pgdec_pkg;

  typedef logic [`PGDEC_BUS_W-1:0] pgdec_bus_t;
  typedef logic [`PGDEC_NTERMS-1:0] pgdec_terms_t;
  typedef logic [`PGDEC_NTERMS-1:0][`PGDEC_BUS_W-1:0] pgdec_tcfg_t;

  typedef enum logic [1:0] {
    PGDEC_ACTIVE,
    PGDEC_SETTLE,
    PGDEC_STANDBY
  } pgdec_pwr_e;

endpackage

// file: pgdec_pterm.sv
`timescale 1ns/1ns
`include "pgdec_defines.svh"

// Every product term is an AND over the care bits of the shared bus.
module pgdec_pterm (
  // Shared input bus
  input  wire pgdec_pkg::pgdec_bus_t   bus_i,
  // Programmed terms
  input  wire pgdec_pkg::pgdec_tcfg_t  care_i,
  input  wire pgdec_pkg::pgdec_tcfg_t  value_i,
  // Term results
  output pgdec_pkg::pgdec_terms_t      term_o
);

  function automatic logic pgdec_match(input pgdec_pkg::pgdec_bus_t b,
                                       input pgdec_pkg::pgdec_bus_t c,
                                       input pgdec_pkg::pgdec_bus_t v);
    pgdec_match = ((b ^ v) & c) == '0;
  endfunction

  always_comb begin
    for (int i = 0; i < `PGDEC_NTERMS; i++) begin
      term_o[i] = pgdec_match(bus_i, care_i[i], value_i[i]);
    end
  end

endmodule

// file: pgdec_host_model.sv
`timescale 1ns/1ns

// ****************************************************************
// Host side of the register bus pins
// ****************************************************************
// Strobes are held long enough to cross the device synchronisers.
module pgdec_host_model (
  // Clock
  input  wire logic        clk_sys_i,
  // Device answer
  input  wire logic [7:0]  dev_data_i,
  input  wire logic        dev_data_oe_i,
  // Host pins
  output logic      [19:0] addr_o,
  output logic      [7:0]  data_o,
  output logic             wr_o,
  output logic             rd_o,
  output logic             psen_o
);
  initial begin
    addr_o = 20'h0_0000;
    data_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
    psen_o = 1'b0;
  end

  task automatic write_reg(input logic [19:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    #1;
    addr_o = a;
    data_o = d;
    wr_o = 1'b1;
    repeat (4) @(posedge clk_sys_i);
    #1;
    wr_o = 1'b0;
    repeat (3) @(posedge clk_sys_i);
    #1;
    // A released data line shows the inverse, never a stale match.
    data_o = ~d;
  endtask

  task automatic read_reg(input logic [19:0] a, output logic [7:0] d,
                          output logic oe);
    @(posedge clk_sys_i);
    #1;
    addr_o = a;
    rd_o = 1'b1;
    repeat (4) @(posedge clk_sys_i);
    #1;
    d = dev_data_i;
    oe = dev_data_oe_i;
    rd_o = 1'b0;
    repeat (3) @(posedge clk_sys_i);
    #1;
  endtask

  task automatic set_pins(input logic [19:0] a, input logic p);
    @(posedge clk_sys_i);
    #1;
    addr_o = a;
    psen_o = p;
  endtask
endmodule

// file: pgdec_top_bench.sv
`timescale 1ns/1ns
`include "pgdec_defines.svh"

module pgdec_top_bench;
  typedef struct packed {
    logic [19:0] a;
    logic [7:0]  d;
    logic [7:0]  pg;
    logic        oe;
  } pgdec_row_s;

  logic                   clk, rst, wide, sec_rdy;
  logic [19:0]            h_addr;
  logic [7:0]             h_wd, h_rd, pa, pb, pc, pmr0, pg_o, rdat;
  logic                   h_wr, h_rdn, h_psen, oe, roe, power_down_input, sram, sram_en, cfg, tst, stby;
  logic [2:0]             pd, ecs;
  logic [4:0]             pmr2;
  logic [7:0]             pri;
  logic [3:0]             sec;
  logic [1:0]             peri;
  logic [15:0]            cells;
  pgdec_pkg::pgdec_tcfg_t care, value;
  int                     mismatches, samples_checked;
  pgdec_row_s             rows [6] = '{
    '{20'h0_80e0, 8'h00, 8'h00, 1'b1}, '{20'h0_80e0, 8'hff, 8'hff, 1'b1},
    '{20'h0_80e0, 8'ha5, 8'ha5, 1'b1}, '{20'h0_80e0, 8'h5a, 8'h5a, 1'b1},
    '{20'h0_80e1, 8'h33, 8'h5a, 1'b0}, '{20'h0_00e0, 8'h77, 8'h5a, 1'b0}};

  pgdec_host_model pgdec_host_model_inst (.clk_sys_i(clk), .dev_data_i(h_rd),
    .dev_data_oe_i(oe), .addr_o(h_addr), .data_o(h_wd), .wr_o(h_wr), .rd_o(h_rdn),
    .psen_o(h_psen));

  pgdec_top pgdec_top_inst (.clk_sys_i(clk), .sys_rst_i(rst), .host_addr_i(h_addr),
    .host_data_i(h_wd), .host_data_o(h_rd), .host_data_oe_o(oe), .host_wr_i(h_wr),
    .host_rd_i(h_rdn), .host_psen_i(h_psen), .host_ale_i(1'b0), .host_aux_i(1'b0),
    .power_down_input_i(power_down_input), .port_a_i(pa), .port_b_i(pb), .port_c_i(pc),
    .port_d_i(pd), .sec_ready_i(sec_rdy), .addr_wide_i(wide),
    .power_mode_reg0_i(pmr0), .power_mode_reg2_i(pmr2), .term_care_i(care),
    .term_value_i(value), .primary_sector_selects_o(pri),
    .secondary_sector_selects_o(sec), .sram_select_o(sram), .sram_enable_o(sram_en),
    .config_register_space_o(cfg), .test_port_select_o(tst), .periph_selects_o(peri),
    .external_chip_selects_o(ecs), .output_cells_o(cells), .page_bits_o(pg_o),
    .arrays_standby_o(stby));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic check_bus(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    check_bus({7'h00, got}, {7'h00, exp});
  endtask

  task automatic report_and_stop;
    if (mismatches == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // A term tests one bus bit; the rest of the term is cleared.
  task automatic open_term(input int t, input int b, input logic v);
    care[t] = '0;
    value[t] = '0;
    care[t][b] = 1'b1;
    value[t][b] = v;
  endtask

  task automatic settle;
    repeat (5) @(posedge clk);
    #1;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    #200000;
    mismatches++;
    report_and_stop();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    rst = 1'b1;
    {wide, sec_rdy, power_down_input} = 3'b000;
    {pa, pb, pc, pd} = 27'h000_0000;
    pmr0 = 8'h08;
    pmr2 = 5'h00;
    // Default terms look for a ready flag that stays low, so none is true.
    for (int t = 0; t < `PGDEC_NTERMS; t++) begin
      open_term(t, `PGDEC_B_RDY, 1'b1);
    end
    open_term(38, 15, 1'b1);
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    check_bus(pg_o, 8'h00);
    check_bit(oe, 1'b0);
    check_bus(pri, 8'h00);
    foreach (rows[i]) begin
      pgdec_host_model_inst.write_reg(rows[i].a, rows[i].d);
      check_bus(pg_o, rows[i].pg);
      check_bit(cfg, rows[i].a[15]);
      pgdec_host_model_inst.read_reg(rows[i].a, rdat, roe);
      check_bit(roe, rows[i].oe);
      if (rows[i].oe) check_bus(rdat, rows[i].pg);
    end
    pa = 8'h3c;
    pgdec_host_model_inst.read_reg(20'h0_800a, rdat, roe);
    check_bus(rdat, 8'h3c);
    pgdec_host_model_inst.write_reg(20'h0_8020, 8'h5a);
    pgdec_host_model_inst.read_reg(20'h0_8020, rdat, roe);
    check_bit(roe, 1'b1);
    check_bus(rdat, 8'h00);
    open_term(2, `PGDEC_B_PAGE, 1'b1);
    pgdec_host_model_inst.write_reg(20'h0_80e0, 8'h01);
    pgdec_host_model_inst.set_pins(20'h0_0000, 1'b0);
    settle();
    check_bus(pri, 8'h01);
    open_term(26, `PGDEC_B_PAGE, 1'b1);
    settle();
    check_bus({sec, pri[3:0]}, 8'h10);
    open_term(42, `PGDEC_B_PAGE + 1, 1'b1);
    pgdec_host_model_inst.write_reg(20'h0_80e0, 8'h03);
    pgdec_host_model_inst.set_pins(20'h0_0002, 1'b0);
    open_term(37, 1, 1'b1);
    settle();
    check_bus({5'h00, ecs}, 8'h01);
    check_bus({sram, sram_en, sec, 2'b00}, 8'hc0);
    open_term(26, `PGDEC_B_RDY, 1'b1);
    open_term(3, `PGDEC_B_ADDR, 1'b1);
    wide = 1'b1;
    pgdec_host_model_inst.set_pins(20'h0_0010, 1'b0);
    settle();
    check_bit(pri[1], 1'b1);
    wide = 1'b0;
    settle();
    check_bit(pri[1], 1'b0);
    open_term(12, `PGDEC_B_CTL + 2, 1'b1);
    pgdec_host_model_inst.set_pins(20'h0_0000, 1'b1);
    settle();
    check_bit(pri[4], 1'b1);
    pmr2 = 5'h04;
    settle();
    check_bit(pri[4], 1'b0);
    open_term(39, `PGDEC_B_PA, 1'b1);
    open_term(40, `PGDEC_B_PA, 1'b1);
    pa = 8'h01;
    settle();
    check_bus({5'h00, tst, peri}, 8'h05);
    care[45] = '0;
    settle();
    check_bit(cells[0], 1'b1);
    pmr0 = 8'h00;
    repeat (12) @(posedge clk);
    #1;
    check_bit(stby, 1'b1);
    repeat (6) begin
      @(posedge clk);
      #1;
      pb = ~pb;
    end
    check_bit(stby, 1'b0);
    pmr0 = 8'h08;
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    check_bus(pg_o, 8'h00);
    report_and_stop();
  end
endmodule
